/* File: fpt_regs.vh */
// Register map, field positions, reset values and timing of the fan PWM and tach block
`ifndef FPT_REGS_VH
`define FPT_REGS_VH

// Register offsets
`define FPT_OFF_FAN_DRIVE_OUT_ONE 8'h56
`define FPT_OFF_FAN_DRIVE_OUT_TWO 8'h57
`define FPT_OFF_CTRL 8'h58
`define FPT_OFF_TACH1 8'h59
`define FPT_OFF_TACH2 8'h5a
`define FPT_OFF_PRELOAD 8'h5b

// Reset values
`define FPT_RST_FAN 8'h00
`define FPT_RST_CTRL 8'h50
`define FPT_RST_TACH 8'h00
`define FPT_RST_PRELOAD 8'h00

// Fan duty register fields
`define FPT_FAN_FORCE 0
`define FPT_FAN_DUTY_LSB 1
`define FPT_FAN_DUTY_MSB 6
`define FPT_FAN_CSEL 7

// Control register fields
`define FPT_CTRL_SRC1 0
`define FPT_CTRL_SRC2 1
`define FPT_CTRL_MUL1 2
`define FPT_CTRL_MUL2 3
`define FPT_CTRL_DIV1_LSB 4
`define FPT_CTRL_DIV2_LSB 6

// Timing: clock period and PWM step times in ns
`define FPT_CLK_NS 8
`define FPT_STEP0_NS 4000
`define FPT_STEP1_NS 1000
`define FPT_STEP2_NS 16000
`define FPT_STEP3_NS 256
`define FPT_TACH_NS 4000

// Cycle counts of the times above at the 8 ns clock, sized for the 16-bit timers
`define FPT_STEP0_CYC 16'h01f4
`define FPT_STEP1_CYC 16'h007d
`define FPT_STEP2_CYC 16'h07d0
`define FPT_STEP3_CYC 16'h0020
`define FPT_TACH_CYC 16'h01f4

`endif

/* File: fpt_fan.v */
// Fan PWM generator and tachometer monitor with byte register port
`timescale 1ns/100ps
//
// Functional notes
// [R1] Force bit holds fan two output high
// [R2] Duty zero low, 32 half, 63 high-63/low-1
// [R3] Fan two clock select picks output frequency
// [R4] Control bit 3 doubles fan two frequency
// [R5] Control bit 2 doubles fan one frequency
// [R6] Control bits 0/1 are clock source selects
// [R7] Fan one tach divisor 1/2/4/8, default two
// [R8] Fan two tach divisor 1/2/4/8, default two
// [R9] Eight-bit count of divided clocks per pulse
// [R10] Reading latched at end of each pulse; code skips it when a preload write falls in the same cycle
// [R11] Reading may be invalid after preload write
// [R12] Reset: fan two 0x00, control 0x50
// [R13] Fan one register mirrors fan two layout
// [R14] 64-step period, high while counter below duty
// [R15] Tach counter saturates at 255
`include "fpt_regs.vh"

module fpt_fan #(
  parameter [15:0] STEP0_CYC = `FPT_STEP0_CYC,
  parameter [15:0] STEP1_CYC = `FPT_STEP1_CYC,
  parameter [15:0] STEP2_CYC = `FPT_STEP2_CYC,
  parameter [15:0] STEP3_CYC = `FPT_STEP3_CYC,
  parameter [15:0] TACH_CYC = `FPT_TACH_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire tach_in_one,
  input wire tach_in_two,
  output wire fan_drive_out_one,
  output wire fan_drive_out_two
);

  // Step length in clk cycles for a source/select pair, halved when doubled
  function [15:0] step_len;
    input src;
    input csel;
    input mul;
    reg [15:0] base;
    begin
      base = STEP0_CYC;
      case ({src, csel})
        2'b00: base = STEP0_CYC;
        2'b01: base = STEP1_CYC;
        2'b10: base = STEP2_CYC;
        2'b11: base = STEP3_CYC;
        default: base = STEP0_CYC;
      endcase
      if (mul) begin
        base = base >> 1;
      end
      if (base == 16'h0000) begin
        base = 16'h0001;
      end
      step_len = base;
    end
  endfunction

  // Mask of divide counter bits for divisor codes 1, 2, 4, 8
  function [2:0] div_mask;
    input [1:0] code;
    begin
      case (code)
        2'b00: div_mask = 3'h0;
        2'b01: div_mask = 3'h1;
        2'b10: div_mask = 3'h3;
        2'b11: div_mask = 3'h7;
        default: div_mask = 3'h1;
      endcase
    end
  endfunction

  // Saturating increment of the tach count
  function [7:0] sat_inc;
    input [7:0] v;
    begin
      if (v == 8'hff) begin
        sat_inc = v;
      end else begin
        sat_inc = v + 8'h01;
      end
    end
  endfunction

  reg [7:0] fan_drive_out_one_q;
  reg [7:0] fan_drive_out_two_q;
  reg [7:0] ctrl_q;
  reg [7:0] preload_q;
  reg [7:0] rdata_d;
  wire [15:0] tach_lat_q;
  reg [15:0] tach_pre_q;
  reg [2:0] tach_div_q;
  wire tach_base_tick;
  wire [1:0] fan_force;
  wire [11:0] fan_duty;
  wire [1:0] fan_csel;
  wire [1:0] fan_src;
  wire [1:0] fan_mul;
  wire [3:0] fan_div;
  wire [1:0] tach_pin;
  wire [1:0] fan_out;
  wire wr_fan_drive_out_one;
  wire wr_fan_drive_out_two;
  wire wr_ctrl;
  wire preload_wr;

  // Per-fan views of the control fields
  assign fan_force = {fan_drive_out_two_q[`FPT_FAN_FORCE], fan_drive_out_one_q[`FPT_FAN_FORCE]};
  assign fan_duty = {fan_drive_out_two_q[`FPT_FAN_DUTY_MSB:`FPT_FAN_DUTY_LSB],
                     fan_drive_out_one_q[`FPT_FAN_DUTY_MSB:`FPT_FAN_DUTY_LSB]}; // R13
  assign fan_csel = {fan_drive_out_two_q[`FPT_FAN_CSEL], fan_drive_out_one_q[`FPT_FAN_CSEL]};
  assign fan_src = {ctrl_q[`FPT_CTRL_SRC2], ctrl_q[`FPT_CTRL_SRC1]}; // R6
  assign fan_mul = {ctrl_q[`FPT_CTRL_MUL2], ctrl_q[`FPT_CTRL_MUL1]};
  assign fan_div = {ctrl_q[`FPT_CTRL_DIV2_LSB+1:`FPT_CTRL_DIV2_LSB],
                    ctrl_q[`FPT_CTRL_DIV1_LSB+1:`FPT_CTRL_DIV1_LSB]};
  assign tach_pin = {tach_in_two, tach_in_one};

  // Write decode, one enable per writable register; read-only offsets have none
  assign wr_fan_drive_out_one = reg_wr && (reg_addr == `FPT_OFF_FAN_DRIVE_OUT_ONE);
  assign wr_fan_drive_out_two = reg_wr && (reg_addr == `FPT_OFF_FAN_DRIVE_OUT_TWO);
  assign wr_ctrl = reg_wr && (reg_addr == `FPT_OFF_CTRL);
  assign preload_wr = reg_wr && (reg_addr == `FPT_OFF_PRELOAD);

  // Software writable registers
  always @(posedge clk) begin
    if (!rst_n) begin
      fan_drive_out_one_q <= `FPT_RST_FAN; // R12
      fan_drive_out_two_q <= `FPT_RST_FAN; // R12
      ctrl_q <= `FPT_RST_CTRL; // R12
      preload_q <= `FPT_RST_PRELOAD;
    end else begin
      if (wr_fan_drive_out_one) begin
        fan_drive_out_one_q <= reg_wdata; // R13
      end
      if (wr_fan_drive_out_two) begin
        fan_drive_out_two_q <= reg_wdata; // R1
      end
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata; // R6
      end
      if (preload_wr) begin
        preload_q <= reg_wdata;
      end
    end
  end

  // Read mux, taken at the strobe edge; idle cycles and unmapped offsets give zero
  // Reads have no side effects, so a repeated read is harmless
  always @* begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `FPT_OFF_FAN_DRIVE_OUT_ONE: rdata_d = fan_drive_out_one_q;
        `FPT_OFF_FAN_DRIVE_OUT_TWO: rdata_d = fan_drive_out_two_q;
        `FPT_OFF_CTRL: rdata_d = ctrl_q;
        `FPT_OFF_TACH1: rdata_d = tach_lat_q[7:0]; // R9 R10
        `FPT_OFF_TACH2: rdata_d = tach_lat_q[15:8]; // R9 R10
        `FPT_OFF_PRELOAD: rdata_d = preload_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Read data register, valid in the cycle after the strobe only
  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // Shared tach time base and divide counter
  // The divide counter is shared, so the first divided tick after a
  // divisor change may come early; the next full pulse reads correctly
  assign tach_base_tick = (tach_pre_q >= TACH_CYC - 16'h0001);

  always @(posedge clk) begin
    if (!rst_n) begin
      tach_pre_q <= 16'h0000;
      tach_div_q <= 3'h0;
    end else if (tach_base_tick) begin
      tach_pre_q <= 16'h0000;
      tach_div_q <= tach_div_q + 3'h1;
    end else begin
      tach_pre_q <= tach_pre_q + 16'h0001;
    end
  end

  // One PWM generator and one tach counter per fan
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_fan
      reg [15:0] step_q;
      reg [5:0] phase_q;
      reg out_q;
      reg out_d;
      reg [2:0] sync_q;
      reg [7:0] cnt_q;
      reg [7:0] cnt_d;
      reg [7:0] lat_q;
      reg [7:0] lat_d;
      wire [15:0] len;
      wire step_tick;
      wire [2:0] mask;
      wire tach_tick;
      wire tach_rise;

      // Step length from source, select and doubler
      assign len = step_len(fan_src[i], fan_csel[i], fan_mul[i]); // R3 R4 R5 R6
      assign step_tick = (step_q >= len - 16'h0001);

      // Step timer and 64-step PWM phase
      always @(posedge clk) begin
        if (!rst_n) begin
          step_q <= 16'h0000;
          phase_q <= 6'h00;
        end else if (step_tick) begin
          step_q <= 16'h0000;
          phase_q <= phase_q + 6'h01; // R14
        end else begin
          step_q <= step_q + 16'h0001;
        end
      end

      // Output level: forced high, else high while phase below duty
      always @* begin
        if (fan_force[i]) begin
          out_d = 1'b1; // R1 R13
        end else begin
          out_d = (phase_q < fan_duty[6*i+5:6*i]); // R2 R14
        end
      end

      // Output register keeps the pin free of decode glitches
      always @(posedge clk) begin
        if (!rst_n) begin
          out_q <= 1'b0;
        end else begin
          out_q <= out_d;
        end
      end
      assign fan_out[i] = out_q;

      // Two-flop synchroniser plus edge history for the tach pin
      // Only the second flop and the history flop feed the edge compare
      always @(posedge clk) begin
        if (!rst_n) begin
          sync_q <= 3'h0;
        end else begin
          sync_q <= {sync_q[1:0], tach_pin[i]};
        end
      end
      assign tach_rise = sync_q[1] && !sync_q[2];

      // Divided count clock per fan
      assign mask = div_mask(fan_div[2*i+1:2*i]); // R7 R8
      assign tach_tick = tach_base_tick && ((tach_div_q & mask) == mask);

      // Count across a pulse, latch at its end, restart from preload
      // A preload write and a pulse end in one cycle skip that pulse's reading
      always @* begin
        cnt_d = cnt_q;
        lat_d = lat_q;
        if (preload_wr) begin
          cnt_d = reg_wdata; // R11
        end else if (tach_rise) begin
          lat_d = cnt_q; // R10
          cnt_d = preload_q;
        end else if (tach_tick) begin
          cnt_d = sat_inc(cnt_q); // R9 R15
        end
      end

      // Live count and latched reading
      always @(posedge clk) begin
        if (!rst_n) begin
          cnt_q <= `FPT_RST_TACH;
          lat_q <= `FPT_RST_TACH;
        end else begin
          cnt_q <= cnt_d;
          lat_q <= lat_d;
        end
      end
      assign tach_lat_q[8*i+7:8*i] = lat_q;
    end
  endgenerate

  // Pin outputs
  assign fan_drive_out_one = fan_out[0];
  assign fan_drive_out_two = fan_out[1];

endmodule

/* File: fpt_fan_monitor.sv */
// Checker for the fan block register port and drive outputs
`timescale 1ns/100ps
module fpt_fan_monitor (
  input wire clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire fan_drive_out_one,
  input wire fan_drive_out_two
);
  reg [7:0] f1_q, f2_q, ct_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shadow copies of the fan one, fan two and control registers
  always @(posedge clk) begin
    if (!rst_n) begin
      f1_q <= 8'h00;
      f2_q <= 8'h00;
      ct_q <= 8'h50;
    end else if (reg_wr) begin
      if (reg_addr == 8'h56) f1_q <= reg_wdata;
      if (reg_addr == 8'h57) f2_q <= reg_wdata;
      if (reg_addr == 8'h58) ct_q <= reg_wdata;
    end
  end
  a_force_two: assert property ($past(f2_q[0], 2) && $past(f2_q[0]) |-> fan_drive_out_two)
    else $error("fan two not forced");
  a_force_one: assert property ($past(f1_q[0], 2) && $past(f1_q[0]) |-> fan_drive_out_one)
    else $error("fan one not forced");
  a_zero_two: assert property ((f2_q[6:0] == 7'h00) [*8] |-> !fan_drive_out_two)
    else $error("fan two high at zero duty");
  a_zero_one: assert property ((f1_q[6:0] == 7'h00) [*8] |-> !fan_drive_out_one)
    else $error("fan one high at zero duty");
  a_ctrl_read: assert property ($past(reg_rd && reg_addr == 8'h58) |-> reg_rdata == $past(ct_q))
    else $error("control readback");
  a_two_read: assert property ($past(reg_rd && reg_addr == 8'h57) |-> reg_rdata == $past(f2_q))
    else $error("fan two readback");
  a_one_read: assert property ($past(reg_rd && reg_addr == 8'h56) |-> reg_rdata == $past(f1_q))
    else $error("fan one readback");
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  c_rise_two: cover property ($rose(fan_drive_out_two));
  c_fall_one: cover property ($fell(fan_drive_out_one));
  c_tach_sat: cover property ($past(reg_rd) && reg_rdata == 8'hff);
endmodule

/* File: fpt_fan_model.sv */
// Fan model: tach pin toggles every half clocks, stands still when half is zero
`timescale 1ns/100ps
module fpt_fan_model (
  input wire clk,
  input wire [15:0] half,
  output reg tach
);
  reg [15:0] c_q = 16'h0000;
  initial tach = 1'b0;
  // Rotor turn counter
  always @(posedge clk) begin
    c_q <= (c_q + 16'h0001 >= half) ? 16'h0000 : c_q + 16'h0001;
    if (half != 16'h0000 && c_q + 16'h0001 >= half) tach <= ~tach;
  end
endmodule

/* File: fpt_fan_tb_top.sv */
// Self-checking bench for the fan PWM and tach block
`timescale 1ns/100ps
module fpt_fan_tb_top;
  reg clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, f;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
  reg [15:0] half = 16'h0000;
  reg [31:0] lf = 32'h3261;
  wire [7:0] reg_rdata;
  wire t1, t2, o1, o2;
  integer fails = 0, n_checks = 0, i, n;
  // 8 ns clock
  always #4 clk = ~clk;
  fpt_fan #(.STEP0_CYC(16'd2), .STEP1_CYC(16'd1), .STEP2_CYC(16'd4), .STEP3_CYC(16'd1), .TACH_CYC(16'd4)) dut (.clk,
    .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tach_in_one(t1), .tach_in_two(t2),
    .fan_drive_out_one(o1), .fan_drive_out_two(o2));
  fpt_fan_model m_one (.clk, .half, .tach(t1));
  fpt_fan_model m_two (.clk, .half, .tach(t2));
  task chk(input [7:0] s, input [7:0] x);
    n_checks = n_checks + 1;
    if (s !== x) begin
      fails = fails + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // High time of half duty for {source, select, doubler}
  function [7:0] ln(input [2:0] k);
    ln = 8'd32 * (k[2:1] == 2'd0 ? (k[0] ? 1 : 2) : k[2:1] == 2'd2 ? (k[0] ? 2 : 4) : 1);
  endfunction
  // Counts clocks of one whole high phase of the chosen output
  task hi;
    n = 0;
    repeat (300) @(posedge clk);
    while ((f ? o2 : o1) !== 1'b0) @(posedge clk);
    while ((f ? o2 : o1) !== 1'b1) @(posedge clk);
    while ((f ? o2 : o1) === 1'b1) begin
      n = n + 1;
      @(posedge clk);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    fails = fails + 1;
    end_of_test;
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      rd(i == 6 ? 8'h40 : 8'h56 + i[7:0]);
      chk(d, i == 2 ? 8'h50 : 8'h00);
    end
    for (i = 0; i < 16; i = i + 1) begin
      lf = nx(lf);
      wr(8'h56 + lf[0], lf[15:8]);
      rd(8'h56 + lf[0]);
      chk(d, lf[15:8]);
    end
    for (i = 0; i < 16; i = i + 1) begin
      f = i[3];
      wr(8'h58, {4'h5, f ? {i[0], 1'b0, i[2], 1'b0} : {1'b0, i[0], 1'b0, i[2]}});
      wr(8'h56 + f, {i[1], 7'h40});
      hi;
      chk(n[7:0], ln(i[2:0]));
    end
    f = 1'b0;
    wr(8'h56, 8'h7e);
    hi;
    chk(n[7:0], 8'd126);
    wr(8'h57, 8'h01);
    repeat (3) @(posedge clk);
    chk({7'h00, o2}, 8'h01);
    half <= 16'd64;
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h58, {i[1:0], i[1:0], 4'h0});
      repeat (600) @(posedge clk);
      rd(8'h59 + i[0]);
      chk({7'h00, d + 8'd1 >= (8'd32 >> i) && d <= (8'd32 >> i) + 8'd1}, 8'h01);
    end
    wr(8'h5b, 8'h40);
    repeat (600) @(posedge clk);
    rd(8'h5b);
    chk(d, 8'h40);
    rd(8'h59);
    chk({7'h00, d >= 8'h43 && d <= 8'h44}, 8'h01);
    wr(8'h58, 8'h00);
    half <= 16'd600;
    repeat (3000) @(posedge clk);
    wr(8'h59, 8'h12);
    rd(8'h59);
    chk(d, 8'hff);
    end_of_test;
  end
endmodule
bind fpt_fan fpt_fan_monitor mon (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .fan_drive_out_one, .fan_drive_out_two);
